// ==== src/adc_input_cfg_pkg.sv ====
// Constants and types for the input configuration and channel select block
package adc_input_cfg_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int CHAN_ADDR_W = 3;
  localparam int MODE_W = 2;
  localparam int RESULT_W_DEFAULT = 12;
  localparam int RESULT_W_ALT = 10;

  // ****************************************
  // Input configuration codes, {bit_hi, bit_lo}
  // ****************************************
  typedef enum logic [1:0] {
    CFG_SINGLE_ENDED = 2'b00,
    CFG_PSEUDO_PAIRS = 2'b01,
    CFG_DIFFERENTIAL = 2'b10,
    CFG_PSEUDO_SEVEN = 2'b11
  } input_cfg_type;

  // ****************************************
  // Reset values and fixed selects
  // ****************************************
  localparam logic [CHAN_ADDR_W-1:0] CHAN_ADDR_RST = 3'h0;
  localparam logic [CHAN_ADDR_W-1:0] COMMON_NEG_CHAN = 3'h7;
  localparam logic [1:0] SEQ_SEL_RST = 2'h0;
  localparam logic [1:0] SEQ_SEL_PLAIN = 2'h0;
  localparam logic RANGE_RST = 1'h0;
  localparam logic RANGE_SINGLE_REF = 1'h0;
  localparam logic RANGE_DOUBLE_REF = 1'h1;
  localparam logic CODING_RST = 1'h0;
  localparam logic CODING_TWOS = 1'h1;
  localparam logic PAIR_POS_BIT = 1'h0;
  localparam logic PAIR_NEG_BIT = 1'h1;

endpackage

// ==== src/adc_input_cfg.sv ====
// Input configuration, channel multiplexer select and output coding of the converter
//
// Contract
// - Mode 0,0: eight single-ended channels
// - Mode 0,1: four pseudo pairs
// - Mode 1,0 four fully differential pairs; 1,1 seven
// - Seven-input mode: eighth input is common negative
// - Sequencer bits zero: plain multichannel, any order
// - Channel from latest write, no automatic stepping
// - Programmable span: reference or twice reference
// - Differential swing maps onto full code range
// - Single-ended: negative input tied to ground
// - Range bit 0 single span, 1 double
// - Results straight binary or twos complement
`timescale 1ns/1ps

module adc_input_cfg #(
  parameter int RESULT_W = adc_input_cfg_pkg::RESULT_W_DEFAULT
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Control register write
  input wire logic cfg_write_i,
  input wire logic input_config_bit_hi_i,
  input wire logic input_config_bit_lo_i,
  input wire logic sequencer_select_a_i,
  input wire logic sequencer_select_b_i,
  input wire logic [adc_input_cfg_pkg::CHAN_ADDR_W-1:0] channel_addr_i,
  input wire logic range_sel_i,
  input wire logic coding_sel_i,
  // Conversion start, active low
  input wire logic conversion_start_n_i,
  // Raw converter result
  input wire logic sar_done_i,
  input wire logic [RESULT_W-1:0] sar_result_i,
  // Multiplexer and front-end controls
  output logic [adc_input_cfg_pkg::CHAN_ADDR_W-1:0] pos_sel_o,
  output logic [adc_input_cfg_pkg::CHAN_ADDR_W-1:0] neg_sel_o,
  output logic neg_to_ground_o,
  output logic range_double_o,
  output logic [adc_input_cfg_pkg::MODE_W-1:0] input_cfg_o,
  output logic plain_multichannel_o,
  output logic conv_start_o,
  // Coded result
  output logic result_valid_o,
  output logic [RESULT_W-1:0] result_o
);
  import adc_input_cfg_pkg::*;

  // ****************************************
  // Parameter check
  // ****************************************
  if (RESULT_W != RESULT_W_DEFAULT && RESULT_W != RESULT_W_ALT) begin : gen_bad_result_w
    $error("adc_input_cfg: RESULT_W must be 12 or 10");
  end
  // Pair decode needs an address bit above the pair bit
  if (CHAN_ADDR_W < 2) begin : gen_bad_addr_w
    $error("adc_input_cfg: CHAN_ADDR_W must be at least 2");
  end

  // ****************************************
  // Pending control register
  // ****************************************
  input_cfg_type pend_cfg_reg;
  logic [1:0] pend_seq_reg;
  logic [CHAN_ADDR_W-1:0] pend_addr_reg;
  logic pend_range_reg;
  logic pend_coding_reg;

  // Writes fill the pending copy only; outputs wait for a start
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pend_cfg_reg <= CFG_SINGLE_ENDED;
      pend_seq_reg <= SEQ_SEL_RST;
      pend_addr_reg <= CHAN_ADDR_RST;
      pend_range_reg <= RANGE_RST;
      pend_coding_reg <= CODING_RST;
    end else if (cfg_write_i) begin
      // Latest write wins
      pend_cfg_reg <= input_cfg_type'({input_config_bit_hi_i, input_config_bit_lo_i});
      pend_seq_reg <= {sequencer_select_a_i, sequencer_select_b_i};
      pend_addr_reg <= channel_addr_i;
      pend_range_reg <= range_sel_i;
      pend_coding_reg <= coding_sel_i;
    end
  end

  // ****************************************
  // Conversion start edge
  // ****************************************
  logic start_prev_reg;
  logic start_fall;

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      // Idle level high, so no false edge after reset
      start_prev_reg <= 1'b1;
    end else begin
      start_prev_reg <= conversion_start_n_i;
    end
  end

  assign start_fall = start_prev_reg & ~conversion_start_n_i;

  // ****************************************
  // Active configuration
  // ****************************************
  input_cfg_type act_cfg_reg;
  logic [1:0] act_seq_reg;
  logic [CHAN_ADDR_W-1:0] act_addr_reg;
  logic act_range_reg;
  logic act_coding_reg;
  logic conv_start_reg;

  // A write in the start cycle waits for the following start
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      act_cfg_reg <= CFG_SINGLE_ENDED;
      act_seq_reg <= SEQ_SEL_RST;
      act_addr_reg <= CHAN_ADDR_RST;
      act_range_reg <= RANGE_RST;
      act_coding_reg <= CODING_RST;
    end else if (start_fall) begin
      // Settings move over only on a start edge
      act_cfg_reg <= pend_cfg_reg;
      act_seq_reg <= pend_seq_reg;
      act_addr_reg <= pend_addr_reg;
      act_range_reg <= pend_range_reg;
      act_coding_reg <= pend_coding_reg;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      conv_start_reg <= 1'b0;
    end else begin
      conv_start_reg <= start_fall;
    end
  end

  // ****************************************
  // Multiplexer select decode
  // ****************************************
  logic [CHAN_ADDR_W-1:0] pos_sel_next;
  logic [CHAN_ADDR_W-1:0] neg_sel_next;
  logic neg_gnd_next;

  always_comb begin
    pos_sel_next = act_addr_reg;
    neg_sel_next = COMMON_NEG_CHAN;
    neg_gnd_next = 1'b0;
    case (act_cfg_reg)
      CFG_SINGLE_ENDED: begin
        pos_sel_next = act_addr_reg;
        neg_gnd_next = 1'b1;
      end
      CFG_DIFFERENTIAL: begin
        // Low address bit swaps the pair polarity
        pos_sel_next = act_addr_reg;
        neg_sel_next = {act_addr_reg[CHAN_ADDR_W-1:1], ~act_addr_reg[0]};
      end
      CFG_PSEUDO_PAIRS: begin
        // Pair bit forced; low address bit ignored
        pos_sel_next = {act_addr_reg[CHAN_ADDR_W-1:1], PAIR_POS_BIT};
        neg_sel_next = {act_addr_reg[CHAN_ADDR_W-1:1], PAIR_NEG_BIT};
      end
      CFG_PSEUDO_SEVEN: begin
        // Address of the common input selects it against itself; not blocked
        pos_sel_next = act_addr_reg;
        neg_sel_next = COMMON_NEG_CHAN;
      end
      default: begin
        pos_sel_next = act_addr_reg;
        neg_gnd_next = 1'b1;
      end
    endcase
  end

  // ****************************************
  // Multiplexer outputs
  // ****************************************
  assign pos_sel_o = pos_sel_next;
  assign neg_sel_o = neg_sel_next;
  assign neg_to_ground_o = neg_gnd_next;

  // ****************************************
  // Span, mode and start outputs
  // ****************************************
  assign range_double_o = (act_range_reg == RANGE_DOUBLE_REF);
  assign input_cfg_o = act_cfg_reg;
  assign plain_multichannel_o = (act_seq_reg == SEQ_SEL_PLAIN);
  assign conv_start_o = conv_start_reg;

  // ****************************************
  // Output coding
  // ****************************************
  logic [RESULT_W-1:0] result_reg;
  logic result_valid_reg;

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      result_reg <= '0;
      result_valid_reg <= 1'b0;
    end else begin
      result_valid_reg <= sar_done_i;
      if (sar_done_i) begin
        // Full swing spans all codes; twos complement flips the top bit
        if (act_coding_reg == CODING_TWOS) begin
          result_reg <= {~sar_result_i[RESULT_W-1], sar_result_i[RESULT_W-2:0]};
        end else begin
          result_reg <= sar_result_i;
        end
      end
    end
  end

  assign result_o = result_reg;
  assign result_valid_o = result_valid_reg;

endmodule // adc_input_cfg

// ==== testbench/adc_input_cfg_assertions.sv ====
// Port checks for the input configuration block
`timescale 1ns/1ps
module adc_input_cfg_assertions import adc_input_cfg_pkg::*; #(
  parameter int RESULT_W = 12
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic conversion_start_n_i,
  input wire logic sar_done_i,
  input wire logic [RESULT_W-1:0] sar_result_i,
  input wire logic [CHAN_ADDR_W-1:0] pos_sel_o,
  input wire logic [CHAN_ADDR_W-1:0] neg_sel_o,
  input wire logic neg_to_ground_o,
  input wire logic range_double_o,
  input wire logic [MODE_W-1:0] input_cfg_o,
  input wire logic conv_start_o,
  input wire logic result_valid_o,
  input wire logic [RESULT_W-1:0] result_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  start_pulse_a: assert property ($fell(conversion_start_n_i) |=> conv_start_o ##1 !conv_start_o)
    else $error("start pulse wrong");
  select_hold_a: assert property (!$stable({pos_sel_o, neg_sel_o, input_cfg_o, range_double_o}) |-> conv_start_o)
    else $error("select moved without start");
  single_ground_a: assert property (neg_to_ground_o == (input_cfg_o == CFG_SINGLE_ENDED))
    else $error("ground tie wrong");
  diff_pair_a: assert property (input_cfg_o == CFG_DIFFERENTIAL |-> neg_sel_o == (pos_sel_o ^ 3'h1))
    else $error("differential pair wrong");
  pseudo_pair_a: assert property (input_cfg_o == CFG_PSEUDO_PAIRS |-> neg_sel_o == {pos_sel_o[2:1], PAIR_NEG_BIT} && pos_sel_o[0] == PAIR_POS_BIT)
    else $error("pseudo pair wrong");
  seven_common_a: assert property (input_cfg_o == CFG_PSEUDO_SEVEN |-> neg_sel_o == COMMON_NEG_CHAN)
    else $error("common input wrong");
  result_valid_a: assert property (result_valid_o == $past(sar_done_i))
    else $error("result valid wrong");
  result_low_a: assert property (result_valid_o |-> result_o[RESULT_W-2:0] == $past(sar_result_i[RESULT_W-2:0]))
    else $error("result bits wrong");
endmodule // adc_input_cfg_assertions

bind adc_input_cfg adc_input_cfg_assertions #(.RESULT_W(RESULT_W)) chk (.*);

// ==== testbench/host_model.sv ====
// Host model writing the control fields and pulsing conversion start
`timescale 1ns/1ps
module host_model (
  // Clock
  input wire logic core_clk_i,
  // Control write and start
  output logic wr_o,
  output logic [8:0] fields_o,
  output logic start_n_o
);
  initial begin
    wr_o = 1'b0;
    fields_o = 9'h000;
    start_n_o = 1'b1;
  end
  // Fields {hi, lo, seq_a, seq_b, addr, range, coding}
  task write_cfg(input logic [8:0] f);
    @(negedge core_clk_i);
    wr_o = 1'b1;
    fields_o = f;
    @(negedge core_clk_i);
    wr_o = 1'b0;
    fields_o = ~f;
  endtask
  task start();
    @(negedge core_clk_i);
    start_n_o = 1'b0;
    @(negedge core_clk_i);
    start_n_o = 1'b1;
    repeat (2) @(negedge core_clk_i);
  endtask
endmodule // host_model

// ==== testbench/tb_top.sv ====
// Self-checking bench for the input configuration block
`timescale 1ns/1ps
module tb_top;
  logic core_clk_i = 1'b0, sys_rst_i = 1'b1, sar_done_i = 1'b0, wr, start_n, gnd, rng, plain, cs, rv;
  logic [11:0] sar_result_i = 12'h000;
  logic [11:0] res;
  logic [8:0] f;
  logic [2:0] pos, neg;
  logic [1:0] cfg;
  logic [5:0] tbl [4] = '{6'h28, 6'h25, 6'h2c, 6'h2f};
  int failures = 0, checked = 0, cycles = 0;
  initial forever #2 core_clk_i = ~core_clk_i;
  host_model host (.core_clk_i(core_clk_i), .wr_o(wr), .fields_o(f), .start_n_o(start_n));
  adc_input_cfg dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .cfg_write_i(wr),
    .input_config_bit_hi_i(f[8]), .input_config_bit_lo_i(f[7]), .sequencer_select_a_i(f[6]),
    .sequencer_select_b_i(f[5]), .channel_addr_i(f[4:2]), .range_sel_i(f[1]),
    .coding_sel_i(f[0]), .conversion_start_n_i(start_n), .sar_done_i(sar_done_i),
    .sar_result_i(sar_result_i), .pos_sel_o(pos), .neg_sel_o(neg), .neg_to_ground_o(gnd),
    .range_double_o(rng), .input_cfg_o(cfg), .plain_multichannel_o(plain), .conv_start_o(cs),
    .result_valid_o(rv), .result_o(res));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      end_of_test;
    end
  end
  initial begin
    repeat (20) @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    @(negedge core_clk_i);
    chk({pos, neg, gnd, cfg, plain, rng}, {3'h0, 3'h7, 1'b1, 2'h0, 1'b1, 1'b0});
    for (int m = 0; m < 4; m++) begin
      host.write_cfg({m[1:0], 2'b00, 3'h5, m[0], 1'b0});
      host.start();
      chk({pos, (m == 0) ? 3'h0 : neg, gnd, cfg, rng}, {tbl[m], m == 0, m[1:0], m[0]});
    end
    host.write_cfg(9'h00c);
    host.write_cfg({4'h0, 3'h6, 2'b00});
    chk(pos, 3'h5);
    host.start();
    chk({pos, plain, rng}, {3'h6, 1'b1, 1'b0});
    host.write_cfg({2'b00, 2'b10, 3'h1, 2'b00});
    host.start();
    host.start();
    chk({pos, plain}, {3'h1, 1'b0});
    for (int c = 0; c < 2; c++) begin
      host.write_cfg({8'h00, c[0]});
      host.start();
      sar_result_i = 12'h8a5;
      sar_done_i = 1'b1;
      @(negedge core_clk_i);
      sar_done_i = 1'b0;
      chk({rv, res}, {1'b1, (c == 1) ? 12'h0a5 : 12'h8a5});
    end
    end_of_test;
  end
endmodule // tb_top
